// ### verilog/ssc_codec.sv
// Channel encoder and decoder for one speech frame in a stolen slot
`timescale 1ns/100ps
`include "ssc_defines.svh"
// Function
// - Stealing: speech only in second half slot, coded apart from signalling
// - Encoder takes a 137-bit uncoded speech frame
// - Check bits cover only the 30 class-2 bits
// - Check polynomial 1 + X + X^4, four parity bits
// - Reordered block: 51, 56, 30, 4 parity, 4 tail, tabulated order
// - Positions 138-141 parity one to four, 142-145 zero tail
// - Only classes 1 and 2 convolutionally coded; class 0 passes uncoded
// - Class 1 at rate 2/3, class 2 at rate 8/17
// - Parity and tail coded with class 2 at its rate
// - Coded block is 216 bits: 51 plus 84 plus 81
// - Rate change keeps encoder memory across class boundary
// - Rate 8/17 keeps 17 listed positions of each 24 outputs
// - Rate 2/3 keeps positions 1, 2, 4 of each 6 outputs
// - 216 coded bits reordered by the signalling stealing interleaver
// - Receive de-interleaves before any decoding
// - Convolutional decoder undoes punctured coding
// - Recompute class-2 parity, mismatch raises bad-frame indicator
// - Receive output: three classes plus bad-frame indicator
// - Decoding strategy chosen per block by stealing status
// - Without stealing the slot is not decoded here; RX_NORMAL_REQ hands it on
// - With stealing only the second 216-bit half is decoded
module ssc_codec #(
  parameter logic [4:0] GEN_A   = 5'h19,
  parameter logic [4:0] GEN_B   = 5'h17,
  parameter logic [4:0] GEN_C   = 5'h1d,
  parameter int         IL_MULT = 101
) (
  input  wire logic                        REF_CLK,
  input  wire logic                        ARST_N,
  input  wire logic                        TX_START,
  input  wire logic [`SSC_FRAME_BITS-1:0]  TX_SPEECH,
  output logic                             TX_BUSY,
  output logic                             TX_DONE,
  output logic      [`SSC_CODED_BITS-1:0]  TX_HALF_SLOT,
  input  wire logic                        RX_START,
  input  wire logic                        RX_STEAL,
  input  wire logic [`SSC_SLOT_BITS-1:0]   RX_SLOT,
  output logic                             RX_BUSY,
  output logic                             RX_NORMAL_REQ,
  output logic                             RX_DONE,
  output logic      [`SSC_C0_BITS-1:0]     RX_CLASS0,
  output logic      [`SSC_C1_BITS-1:0]     RX_CLASS1,
  output logic      [`SSC_C2_BITS-1:0]     RX_CLASS2,
  output logic                             RX_BAD_FRAME
);
  localparam int NST = 16;

  // Speech bit number for each reordered position
  localparam logic [7:0] ORDER [0:`SSC_FRAME_BITS-1] = '{
    8'h23, 8'h24, 8'h25, 8'h26, 8'h27, 8'h28, 8'h29, 8'h2a, 8'h2b, 8'h2f, 8'h30, 8'h38,
    8'h3d, 8'h3e, 8'h3f, 8'h40, 8'h41, 8'h42, 8'h43, 8'h44, 8'h45, 8'h46, 8'h4a, 8'h4b,
    8'h53, 8'h58, 8'h59, 8'h5a, 8'h5b, 8'h5c, 8'h5d, 8'h5e, 8'h5f, 8'h60, 8'h61, 8'h65,
    8'h66, 8'h6e, 8'h73, 8'h74, 8'h75, 8'h76, 8'h77, 8'h78, 8'h79, 8'h7a, 8'h7b, 8'h7c,
    8'h80, 8'h81, 8'h89,
    8'h3a, 8'h55, 8'h70, 8'h36, 8'h51, 8'h6c, 8'h87, 8'h32, 8'h4d, 8'h68, 8'h83, 8'h2d,
    8'h48, 8'h63, 8'h7e, 8'h37, 8'h52, 8'h6d, 8'h88, 8'h05, 8'h0d, 8'h22, 8'h08, 8'h10,
    8'h11, 8'h16, 8'h17, 8'h18, 8'h19, 8'h1a, 8'h06, 8'h0e, 8'h07, 8'h0f, 8'h3c, 8'h57,
    8'h72, 8'h2e, 8'h49, 8'h64, 8'h7f, 8'h2c, 8'h47, 8'h62, 8'h7d, 8'h21, 8'h31, 8'h4c,
    8'h67, 8'h82, 8'h3b, 8'h56, 8'h71, 8'h39, 8'h54, 8'h6f,
    8'h12, 8'h13, 8'h14, 8'h15, 8'h1f, 8'h20, 8'h35, 8'h50, 8'h6b, 8'h86, 8'h01, 8'h02,
    8'h03, 8'h04, 8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h1b, 8'h1c, 8'h1d, 8'h1e, 8'h34, 8'h4f,
    8'h6a, 8'h85, 8'h33, 8'h4e, 8'h69, 8'h84
  };

  // Serial division, first class-2 bit enters first; parity one is the X^3 term
  function automatic logic [3:0] crc4(input logic [`SSC_C2_BITS-1:0] d);
    logic [3:0] r;
    logic       fb;
    r = 4'h0;
    for (int k = 0; k < `SSC_C2_BITS; k++) begin
      fb = d[k] ^ r[3];
      r  = {r[2:0], 1'b0} ^ ({4{fb}} & `SSC_CRC_POLY);
    end
    crc4 = {r[0], r[1], r[2], r[3]};
  endfunction

  // Mother code: rate 1/3, four memory cells, newest input in the top bit
  function automatic logic [2:0] conv_out(input logic [3:0] st, input logic u);
    logic [4:0] taps;
    taps     = {u, st};
    conv_out = {^(taps & GEN_C), ^(taps & GEN_B), ^(taps & GEN_A)};
  endfunction

  // Kept mother outputs of one trellis step; phase is always a multiple of three
  function automatic logic [2:0] keep_mask(input logic [4:0] ph, input logic cls2);
    logic [4:0] p6;
    keep_mask = 3'h0;
    p6        = ph % `SSC_PERIOD_R23;
    for (int k = 0; k < 3; k++) begin
      if (cls2) begin
        keep_mask[k] = 1'(`SSC_KEEP_R817 >> (ph + 5'(k)));
      end else begin
        keep_mask[k] = 1'(`SSC_KEEP_R23 >> (p6 + 5'(k)));
      end
    end
  endfunction

  // Write positions of the kept outputs and the pointer after the step
  function automatic logic [31:0] slot_of(input logic [7:0] ptr, input logic [2:0] m,
                                          input int k);
    logic [7:0] pos;
    pos = ptr;
    for (int j = 0; j < k; j++) begin
      pos = pos + 8'(m[j]);
    end
    slot_of = 32'(pos);
  endfunction

  function automatic logic [4:0] next_phase(input logic [4:0] ph);
    next_phase = (ph + 5'h03 == `SSC_PERIOD_R817) ? 5'h00 : ph + 5'h03;
  endfunction

  // ---------------------------------------------------------------- encoder
  ssc_pkg::ssc_tx_state_t           tx_state_q;
  logic [6:0]                       tx_step_q;
  logic [7:0]                       tx_ptr_q;
  logic [4:0]                       tx_ph_q;
  logic [3:0]                       enc_st_q;
  logic [`SSC_FRAME_BITS-1:0]       tx_frame_q;
  logic [`SSC_CODED_BITS-1:0]       coded_q;
  logic [`SSC_T2_BITS-1:0]          t2;
  logic [`SSC_CODED_BITS-1:0]       tx_il;
  logic                             enc_u;
  logic                             enc_cls2;
  logic [2:0]                       enc_g;
  logic [2:0]                       enc_keep;

  // Tail bits stay at zero, so the trellis always ends in state zero
  always_comb begin
    t2 = '0;
    for (int i = 0; i < `SSC_FRAME_BITS; i++) begin
      t2[i] = tx_frame_q[ORDER[i] - 8'h01];
    end
    t2[`SSC_PAR_POS +: `SSC_PAR_BITS] = crc4(t2[`SSC_C2_POS +: `SSC_C2_BITS]);
  end

  always_comb begin
    enc_u    = t2[`SSC_C0_BITS + int'(tx_step_q)];
    enc_cls2 = tx_step_q >= 7'(`SSC_C1_BITS);
    enc_g    = conv_out(enc_st_q, enc_u);
    enc_keep = keep_mask(tx_ph_q, enc_cls2);
  end

  always_comb begin
    tx_il = '0;
    for (int i = 0; i < `SSC_CODED_BITS; i++) begin
      tx_il[(IL_MULT * i) % `SSC_CODED_BITS] = coded_q[i];
    end
  end

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      tx_state_q <= ssc_pkg::TXS_IDLE;
    end else begin
      case (tx_state_q)
        ssc_pkg::TXS_IDLE: begin
          if (TX_START) begin
            tx_state_q <= ssc_pkg::TXS_RUN;
          end
        end
        ssc_pkg::TXS_RUN: begin
          if (tx_step_q == 7'(`SSC_CONV_STEPS - 1)) begin
            tx_state_q <= ssc_pkg::TXS_FIN;
          end
        end
        default: tx_state_q <= ssc_pkg::TXS_IDLE;
      endcase
    end
  end

  // Encoder memory runs on through the class change; cleared only per block
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      tx_frame_q <= '0;
      tx_step_q  <= 7'h00;
      tx_ptr_q   <= 8'h00;
      tx_ph_q    <= 5'h00;
      enc_st_q   <= 4'h0;
    end else if (tx_state_q == ssc_pkg::TXS_IDLE) begin
      if (TX_START) begin
        tx_frame_q <= TX_SPEECH;
      end
      tx_step_q <= 7'h00;
      tx_ptr_q  <= 8'(`SSC_C0_BITS);
      tx_ph_q   <= 5'h00;
      enc_st_q  <= 4'h0;
    end else if (tx_state_q == ssc_pkg::TXS_RUN) begin
      tx_step_q <= tx_step_q + 7'h01;
      tx_ptr_q  <= 8'(slot_of(tx_ptr_q, enc_keep, 3));
      tx_ph_q   <= next_phase(tx_ph_q);
      enc_st_q  <= {enc_u, enc_st_q[3:1]};
    end
  end

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      coded_q <= '0;
    end else if (tx_state_q == ssc_pkg::TXS_RUN) begin
      coded_q[`SSC_C0_BITS-1:0] <= t2[`SSC_C0_BITS-1:0];
      for (int k = 0; k < 3; k++) begin
        if (enc_keep[k]) begin
          coded_q[slot_of(tx_ptr_q, enc_keep, k)] <= enc_g[k];
        end
      end
    end
  end

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      TX_HALF_SLOT <= '0;
      TX_DONE      <= 1'b0;
    end else begin
      TX_DONE <= tx_state_q == ssc_pkg::TXS_FIN;
      if (tx_state_q == ssc_pkg::TXS_FIN) begin
        TX_HALF_SLOT <= tx_il;
      end
    end
  end

  assign TX_BUSY = tx_state_q != ssc_pkg::TXS_IDLE;

  // ---------------------------------------------------------------- decoder
  ssc_pkg::ssc_rx_state_t           rx_state_q;
  logic [`SSC_CODED_BITS-1:0]       half_q;
  logic [`SSC_CODED_BITS-1:0]       dein;
  logic [6:0]                       rx_step_q;
  logic [7:0]                       rx_ptr_q;
  logic [4:0]                       rx_ph_q;
  logic [3:0]                       tb_st_q;
  logic [`SSC_T2_BITS-1:0]          dec_q;
  ssc_pkg::ssc_metric_t             pm_q [0:NST-1];
  ssc_pkg::ssc_metric_t             pm_new [0:NST-1];
  logic [NST-1:0]                   pick;
  logic [NST-1:0]                   surv_q [0:`SSC_CONV_STEPS-1];
  logic [2:0]                       rx_keep;
  logic [2:0]                       rx_sym;
  logic [1:0]                       bm [0:NST-1][0:1];

  always_comb begin
    for (int i = 0; i < `SSC_CODED_BITS; i++) begin
      dein[i] = half_q[(IL_MULT * i) % `SSC_CODED_BITS];
    end
  end

  // Punctured positions carry no weight in the branch metric
  always_comb begin
    logic [2:0] g;
    logic [2:0] dif;
    int         pos;
    g       = 3'h0;
    dif     = 3'h0;
    pos     = 0;
    rx_keep = keep_mask(rx_ph_q, rx_step_q >= 7'(`SSC_C1_BITS));
    rx_sym  = 3'h0;
    for (int k = 0; k < 3; k++) begin
      pos = int'(slot_of(rx_ptr_q, rx_keep, k));
      if (rx_keep[k] && pos < `SSC_CODED_BITS) begin
        rx_sym[k] = dein[pos];
      end
    end
    for (int s = 0; s < NST; s++) begin
      for (int b = 0; b < 2; b++) begin
        g        = conv_out({s[2:0], 1'(b)}, s[3]);
        dif      = (g ^ rx_sym) & rx_keep;
        bm[s][b] = 2'(dif[0]) + 2'(dif[1]) + 2'(dif[2]);
      end
    end
  end

  for (genvar s = 0; s < NST; s++) begin : g_acs
    ssc_acs #(
      .MW (`SSC_PM_WIDTH),
      .BW (2)
    ) u_acs (
      .pm_zero  (pm_q[(2 * s) % NST]),
      .pm_one   (pm_q[(2 * s + 1) % NST]),
      .bm_zero  (bm[s][0]),
      .bm_one   (bm[s][1]),
      .pm_next  (pm_new[s]),
      .pick_one (pick[s])
    );
  end

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rx_state_q <= ssc_pkg::RXS_IDLE;
    end else begin
      case (rx_state_q)
        ssc_pkg::RXS_IDLE: begin
          if (RX_START && RX_STEAL) begin
            rx_state_q <= ssc_pkg::RXS_ACS;
          end
        end
        ssc_pkg::RXS_ACS: begin
          if (rx_step_q == 7'(`SSC_CONV_STEPS - 1)) begin
            rx_state_q <= ssc_pkg::RXS_TRACE;
          end
        end
        ssc_pkg::RXS_TRACE: begin
          if (rx_step_q == 7'h00) begin
            rx_state_q <= ssc_pkg::RXS_CHECK;
          end
        end
        default: rx_state_q <= ssc_pkg::RXS_IDLE;
      endcase
    end
  end

  // Second half slot is the upper half of the slot word
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      half_q        <= '0;
      RX_NORMAL_REQ <= 1'b0;
    end else begin
      RX_NORMAL_REQ <= rx_state_q == ssc_pkg::RXS_IDLE && RX_START && !RX_STEAL;
      if (rx_state_q == ssc_pkg::RXS_IDLE && RX_START && RX_STEAL) begin
        half_q <= RX_SLOT[`SSC_SLOT_BITS-1:`SSC_CODED_BITS];
      end
    end
  end

  // Step counter counts up through the trellis and back down in traceback
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rx_step_q <= 7'h00;
      rx_ptr_q  <= 8'h00;
      rx_ph_q   <= 5'h00;
    end else if (rx_state_q == ssc_pkg::RXS_IDLE) begin
      rx_step_q <= 7'h00;
      rx_ptr_q  <= 8'(`SSC_C0_BITS);
      rx_ph_q   <= 5'h00;
    end else if (rx_state_q == ssc_pkg::RXS_ACS) begin
      if (rx_step_q != 7'(`SSC_CONV_STEPS - 1)) begin
        rx_step_q <= rx_step_q + 7'h01;
      end
      rx_ptr_q <= 8'(slot_of(rx_ptr_q, rx_keep, 3));
      rx_ph_q  <= next_phase(rx_ph_q);
    end else if (rx_state_q == ssc_pkg::RXS_TRACE && rx_step_q != 7'h00) begin
      rx_step_q <= rx_step_q - 7'h01;
    end
  end

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      for (int s = 0; s < NST; s++) begin
        pm_q[s] <= '0;
      end
    end else if (rx_state_q == ssc_pkg::RXS_IDLE) begin
      for (int s = 0; s < NST; s++) begin
        pm_q[s] <= (s == 0) ? '0 : `SSC_PM_INIT;
      end
    end else if (rx_state_q == ssc_pkg::RXS_ACS) begin
      pm_q <= pm_new;
    end
  end

  // Survivor bits in flip-flops: area traded for a fixed, short traceback
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      for (int j = 0; j < `SSC_CONV_STEPS; j++) begin
        surv_q[j] <= '0;
      end
    end else if (rx_state_q == ssc_pkg::RXS_ACS) begin
      surv_q[rx_step_q] <= pick;
    end
  end

  // Traceback starts in state zero, which the tail bits force
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      tb_st_q <= 4'h0;
      dec_q   <= '0;
    end else if (rx_state_q == ssc_pkg::RXS_ACS) begin
      tb_st_q                   <= 4'h0;
      dec_q[`SSC_C0_BITS-1:0]   <= dein[`SSC_C0_BITS-1:0];
    end else if (rx_state_q == ssc_pkg::RXS_TRACE) begin
      dec_q[`SSC_C0_BITS + int'(rx_step_q)] <= tb_st_q[3];
      tb_st_q <= {tb_st_q[2:0], surv_q[rx_step_q][tb_st_q]};
    end
  end

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      RX_CLASS0    <= '0;
      RX_CLASS1    <= '0;
      RX_CLASS2    <= '0;
      RX_BAD_FRAME <= 1'b0;
      RX_DONE      <= 1'b0;
    end else begin
      RX_DONE <= rx_state_q == ssc_pkg::RXS_CHECK;
      if (rx_state_q == ssc_pkg::RXS_CHECK) begin
        RX_CLASS0    <= dec_q[`SSC_C0_BITS-1:0];
        RX_CLASS1    <= dec_q[`SSC_C0_BITS +: `SSC_C1_BITS];
        RX_CLASS2    <= dec_q[`SSC_C2_POS +: `SSC_C2_BITS];
        RX_BAD_FRAME <= crc4(dec_q[`SSC_C2_POS +: `SSC_C2_BITS])
                        != dec_q[`SSC_PAR_POS +: `SSC_PAR_BITS];
      end
    end
  end

  assign RX_BUSY = rx_state_q != ssc_pkg::RXS_IDLE;

endmodule // ssc_codec

// ### verilog/ssc_defines.svh
// Frame sizes, field positions, puncturing masks and per-block path-metric start values of the stolen-slot codec
`ifndef SSC_DEFINES_SVH
`define SSC_DEFINES_SVH

`define SSC_FRAME_BITS   137
`define SSC_C0_BITS      51
`define SSC_C1_BITS      56
`define SSC_C2_BITS      30
`define SSC_C2_POS       107
`define SSC_PAR_BITS     4
`define SSC_PAR_POS      137
`define SSC_TAIL_BITS    4
`define SSC_TAIL_POS     141
`define SSC_T2_BITS      145
`define SSC_CONV_STEPS   94
`define SSC_CODED_BITS   216
`define SSC_SLOT_BITS    432
`define SSC_CRC_POLY     4'h3
`define SSC_KEEP_R23     6'h0b
`define SSC_PERIOD_R23   5'h06
`define SSC_KEEP_R817    24'h6db6df
`define SSC_PERIOD_R817  5'h18
`define SSC_PM_WIDTH     10
`define SSC_PM_INIT      10'h100

`endif

// ### verilog/ssc_pkg.sv
// Types shared by the stolen-slot speech codec
`include "ssc_defines.svh"
package ssc_pkg;
  typedef enum logic [1:0] {
    TXS_IDLE = 2'h0,
    TXS_RUN  = 2'h1,
    TXS_FIN  = 2'h3
  } ssc_tx_state_t;

  typedef enum logic [2:0] {
    RXS_IDLE  = 3'h0,
    RXS_ACS   = 3'h1,
    RXS_TRACE = 3'h3,
    RXS_CHECK = 3'h2
  } ssc_rx_state_t;

  typedef logic [`SSC_PM_WIDTH-1:0] ssc_metric_t;
endpackage

// ### verilog/ssc_acs.sv
// Add-compare-select cell for one trellis state
`timescale 1ns/100ps
module ssc_acs #(
  parameter int MW = 10,
  parameter int BW = 2
) (
  input  wire logic [MW-1:0] pm_zero,
  input  wire logic [MW-1:0] pm_one,
  input  wire logic [BW-1:0] bm_zero,
  input  wire logic [BW-1:0] bm_one,
  output logic      [MW-1:0] pm_next,
  output logic               pick_one
);
  logic [MW-1:0] sum_zero;
  logic [MW-1:0] sum_one;

  always_comb begin
    sum_zero = pm_zero + MW'(bm_zero);
    sum_one  = pm_one + MW'(bm_one);
    // Ties keep the even predecessor
    pick_one = sum_one < sum_zero;
    pm_next  = pick_one ? sum_one : sum_zero;
  end
endmodule // ssc_acs

// ### testbench/ssc_link_model.sv
// Radio link model: loops the coded half slot back behind a changing signalling half
`timescale 1ns/100ps
`include "ssc_defines.svh"
module ssc_link_model (
  input  wire logic                       clk,
  input  wire logic                       arst_n,
  input  wire logic                       tx_done,
  input  wire logic [`SSC_CODED_BITS-1:0] tx_half,
  input  wire logic                       inj_en,
  input  wire logic [`SSC_CODED_BITS-1:0] inj_half,
  input  wire logic [`SSC_CODED_BITS-1:0] err_mask,
  output logic      [`SSC_SLOT_BITS-1:0]  rx_slot
);
  logic [`SSC_CODED_BITS-1:0] cap_q;
  logic [`SSC_CODED_BITS-1:0] sig_q;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) cap_q <= '0;
    else if (tx_done) cap_q <= tx_half;
  end
  // Signalling half toggles every cycle so a decoder reading it is caught
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) sig_q <= {108{2'h1}};
    else sig_q <= ~sig_q;
  end
  assign rx_slot = {(inj_en ? inj_half : cap_q) ^ err_mask, sig_q};
endmodule // ssc_link_model

// ### testbench/ssc_codec_checker.sv
// Port timing checks for the stolen-slot speech codec
`timescale 1ns/100ps
`include "ssc_defines.svh"
module ssc_codec_checker (
  input wire logic                       REF_CLK,
  input wire logic                       ARST_N,
  input wire logic                       TX_START,
  input wire logic                       TX_BUSY,
  input wire logic                       TX_DONE,
  input wire logic [`SSC_CODED_BITS-1:0] TX_HALF_SLOT,
  input wire logic                       RX_START,
  input wire logic                       RX_STEAL,
  input wire logic                       RX_BUSY,
  input wire logic                       RX_NORMAL_REQ,
  input wire logic                       RX_DONE,
  input wire logic [`SSC_C0_BITS-1:0]    RX_CLASS0,
  input wire logic [`SSC_C1_BITS-1:0]    RX_CLASS1,
  input wire logic [`SSC_C2_BITS-1:0]    RX_CLASS2,
  input wire logic                       RX_BAD_FRAME
);
  logic tx_take;
  logic rx_steal_take;
  logic norm_take_q;
  assign tx_take = TX_START && !TX_BUSY;
  assign rx_steal_take = RX_START && RX_STEAL && !RX_BUSY;
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) norm_take_q <= 1'h0;
    else norm_take_q <= RX_START && !RX_STEAL && !RX_BUSY;
  end
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!ARST_N);
  tx_busy_span_a: assert property (tx_take |=> TX_BUSY [*8] ##87 TX_BUSY ##1 (TX_DONE && !TX_BUSY))
    else $error("encoder busy span or done moment wrong");
  tx_done_origin_a: assert property (TX_DONE |-> $past(tx_take, 96))
    else $error("encoder done without a start 96 cycles before");
  tx_done_pulse_a: assert property (TX_DONE |=> !TX_DONE)
    else $error("encoder done longer than one cycle");
  tx_slot_hold_a: assert property ($changed(TX_HALF_SLOT) |-> TX_DONE)
    else $error("half slot changed outside done");
  rx_steal_span_a: assert property (rx_steal_take |=> RX_BUSY [*8] ##181 RX_BUSY ##1 (RX_DONE && !RX_BUSY))
    else $error("stolen slot decode span or done moment wrong");
  rx_done_origin_a: assert property (RX_DONE |-> $past(rx_steal_take, 190))
    else $error("decoder done without a stolen slot start");
  rx_normal_req_a: assert property (RX_NORMAL_REQ == norm_take_q)
    else $error("normal slot request does not follow its start");
  rx_normal_idle_a: assert property ((RX_START && !RX_STEAL && !RX_BUSY) |=> !RX_BUSY)
    else $error("normal slot started a local decode");
  rx_out_hold_a: assert property ($changed({RX_CLASS0, RX_CLASS1, RX_CLASS2, RX_BAD_FRAME}) |-> RX_DONE)
    else $error("decoder outputs changed outside done");
  cover property (tx_take);
  cover property (rx_steal_take ##190 RX_BAD_FRAME);
  cover property (RX_NORMAL_REQ ##1 RX_NORMAL_REQ);
endmodule // ssc_codec_checker
bind ssc_codec ssc_codec_checker u_chk (
  .REF_CLK(REF_CLK), .ARST_N(ARST_N), .TX_START(TX_START), .TX_BUSY(TX_BUSY),
  .TX_DONE(TX_DONE), .TX_HALF_SLOT(TX_HALF_SLOT), .RX_START(RX_START), .RX_STEAL(RX_STEAL),
  .RX_BUSY(RX_BUSY), .RX_NORMAL_REQ(RX_NORMAL_REQ), .RX_DONE(RX_DONE), .RX_CLASS0(RX_CLASS0),
  .RX_CLASS1(RX_CLASS1), .RX_CLASS2(RX_CLASS2), .RX_BAD_FRAME(RX_BAD_FRAME)
);

// ### testbench/tb_top.sv
// Self-checking bench for the stolen-slot speech codec
`timescale 1ns/100ps
`include "ssc_defines.svh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_errors++; \
  $display("[ERR] t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module tb_top;
  localparam logic [4:0] G_A  = 5'h19;
  localparam logic [4:0] G_B  = 5'h17;
  localparam logic [4:0] G_C  = 5'h1d;
  localparam int         IL_M = 101;
  logic                       REF_CLK, ARST_N, TX_START, TX_BUSY, TX_DONE, RX_START, RX_STEAL;
  logic                       RX_BUSY, RX_NORMAL_REQ, RX_DONE, RX_BAD_FRAME, inj_en;
  logic [`SSC_FRAME_BITS-1:0] TX_SPEECH;
  logic [`SSC_CODED_BITS-1:0] TX_HALF_SLOT, inj_half, err_mask, exp_hs;
  logic [`SSC_SLOT_BITS-1:0]  RX_SLOT;
  logic [`SSC_C0_BITS-1:0]    RX_CLASS0;
  logic [`SSC_C1_BITS-1:0]    RX_CLASS1;
  logic [`SSC_C2_BITS-1:0]    RX_CLASS2;
  logic [`SSC_T2_BITS-1:0]    exp_t2;
  int                         n_errors, cmp_count, cyc;
  int tbl[137] = '{35,36,37,38,39,40,41,42,43,47,48,56,61,62,63,64,65,66,67,68,69,70,74,75,83,
    88,89,90,91,92,93,94,95,96,97,101,102,110,115,116,117,118,119,120,121,122,123,124,128,129,
    137,58,85,112,54,81,108,135,50,77,104,131,45,72,99,126,55,82,109,136,5,13,34,8,16,17,22,23,
    24,25,26,6,14,7,15,60,87,114,46,73,100,127,44,71,98,125,33,49,76,103,130,59,86,113,57,84,
    111,18,19,20,21,31,32,53,80,107,134,1,2,3,4,9,10,11,12,27,28,29,30,52,79,106,133,51,78,105,
    132};
  ssc_codec #(.GEN_A(G_A), .GEN_B(G_B), .GEN_C(G_C), .IL_MULT(IL_M)) DUT (
    .REF_CLK(REF_CLK), .ARST_N(ARST_N), .TX_START(TX_START), .TX_SPEECH(TX_SPEECH),
    .TX_BUSY(TX_BUSY), .TX_DONE(TX_DONE), .TX_HALF_SLOT(TX_HALF_SLOT), .RX_START(RX_START),
    .RX_STEAL(RX_STEAL), .RX_SLOT(RX_SLOT), .RX_BUSY(RX_BUSY), .RX_NORMAL_REQ(RX_NORMAL_REQ),
    .RX_DONE(RX_DONE), .RX_CLASS0(RX_CLASS0), .RX_CLASS1(RX_CLASS1), .RX_CLASS2(RX_CLASS2),
    .RX_BAD_FRAME(RX_BAD_FRAME)
  );
  ssc_link_model u_link (
    .clk(REF_CLK), .arst_n(ARST_N), .tx_done(TX_DONE), .tx_half(TX_HALF_SLOT),
    .inj_en(inj_en), .inj_half(inj_half), .err_mask(err_mask), .rx_slot(RX_SLOT)
  );
  // Reference encoder; bad_par inverts the parity to provoke a bad frame
  task automatic ref_enc(input logic [`SSC_FRAME_BITS-1:0] sp, input logic bad_par);
    logic [3:0] crc, st;
    logic [4:0] r;
    logic [2:0] mo;
    logic [`SSC_CODED_BITS-1:0] cod;
    int n, m;
    for (int k = 0; k < 137; k++) exp_t2[k] = sp[tbl[k]-1];
    crc = 4'h0;
    for (int k = 107; k < 137; k++) crc = {crc[2:0], 1'h0} ^ ((exp_t2[k] ^ crc[3]) ? 4'h3 : 4'h0);
    exp_t2[140:137] = {crc[0], crc[1], crc[2], crc[3]} ^ {4{bad_par}};
    exp_t2[144:141] = 4'h0;
    cod = '0;
    cod[50:0] = exp_t2[50:0];
    st = 4'h0;
    n = 51;
    m = 0;
    for (int k = 51; k < 145; k++) begin
      r = {exp_t2[k], st};
      mo = {^(r & G_C), ^(r & G_B), ^(r & G_A)};
      for (int j = 0; j < 3; j++) begin
        if (k < 107 ? ((m % 6) inside {0, 1, 3}) : !((m % 24) >= 5 && (m % 3) == 2)) begin
          cod[n] = mo[j];
          n++;
        end
        m++;
      end
      st = {exp_t2[k], st[3:1]};
    end
    for (int i = 0; i < 216; i++) exp_hs[(IL_M * i) % 216] = cod[i];
  endtask
  task automatic wait_hi(input int which, output int n);
    n = 0;
    do begin
      @(negedge REF_CLK);
      n++;
    end while (n < 400 && !(which == 0 ? TX_DONE === 1'h1 : RX_DONE === 1'h1));
  endtask
  // Poke tries a refused start while busy; returns on the done cycle for back-to-back use
  task automatic enc_frame(input logic [`SSC_FRAME_BITS-1:0] sp, input logic poke);
    int n;
    ref_enc(sp, 1'h0);
    TX_SPEECH = sp;
    TX_START = 1'h1;
    @(negedge REF_CLK);
    TX_START = 1'h0;
    `CHK(TX_BUSY, 1'h1)
    if (poke) begin
      repeat (5) @(negedge REF_CLK);
      TX_START = 1'h1;
      TX_SPEECH = ~sp;
      @(negedge REF_CLK);
      TX_START = 1'h0;
    end
    wait_hi(0, n);
    `CHK(n + (poke ? 7 : 1), 96)
    `CHK(TX_HALF_SLOT, exp_hs)
    `CHK(TX_BUSY, 1'h0)
  endtask
  task automatic dec_frame(input logic [`SSC_FRAME_BITS-1:0] sp, input logic bad,
                           input int flip0, input int flip1);
    int n;
    @(negedge REF_CLK);
    ref_enc(sp, bad);
    inj_half = exp_hs;
    inj_en = bad;
    err_mask = '0;
    if (flip0 >= 0) err_mask[(IL_M * flip0) % 216] = 1'h1;
    if (flip1 >= 0) err_mask[(IL_M * flip1) % 216] = 1'h1;
    RX_STEAL = 1'h1;
    RX_START = 1'h1;
    @(negedge REF_CLK);
    RX_START = 1'h0;
    wait_hi(1, n);
    `CHK(n + 1, 190)
    `CHK(RX_CLASS0, exp_t2[50:0] ^ (flip0 >= 0 ? 51'h1 << flip0 : 51'h0))
    `CHK(RX_CLASS1, exp_t2[106:51])
    `CHK(RX_CLASS2, exp_t2[136:107])
    `CHK(RX_BAD_FRAME, bad)
    `CHK(RX_BUSY, 1'h0)
    inj_en = 1'h0;
    err_mask = '0;
  endtask
  // Two normal slots on consecutive edges, each dispatched away
  task automatic dec_normal();
    RX_STEAL = 1'h0;
    RX_START = 1'h1;
    @(negedge REF_CLK);
    `CHK({RX_NORMAL_REQ, RX_BUSY}, 2'h2)
    @(negedge REF_CLK);
    RX_START = 1'h0;
    `CHK(RX_NORMAL_REQ, 1'h1)
    @(negedge REF_CLK);
    `CHK({RX_NORMAL_REQ, RX_DONE}, 2'h0)
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    REF_CLK = 1'h0;
    forever #25 REF_CLK = ~REF_CLK;
  end
  // Whole run needs under eight hundred cycles
  initial begin
    cyc = 0;
    forever begin
      @(posedge REF_CLK);
      cyc++;
      if (cyc == 3000) begin
        n_errors++;
        results();
      end
    end
  end
  initial begin
    n_errors = 0;
    cmp_count = 0;
    ARST_N = 1'h0;
    TX_START = 1'h0;
    TX_SPEECH = '0;
    RX_START = 1'h0;
    RX_STEAL = 1'h0;
    inj_en = 1'h0;
    inj_half = '0;
    err_mask = '0;
    repeat (3) @(negedge REF_CLK);
    ARST_N = 1'h1;
    `CHK({TX_BUSY, TX_DONE, RX_BUSY, RX_DONE, RX_NORMAL_REQ, RX_BAD_FRAME}, 6'h00)
    `CHK(TX_HALF_SLOT, {`SSC_CODED_BITS{1'h0}})
    enc_frame({`SSC_FRAME_BITS{1'h1}}, 1'h0);
    enc_frame(137'h1_5ac3a5_96f0_0ff1_e2d4_b687_9a5c_3e1f_7042, 1'h1);
    dec_frame(137'h1_5ac3a5_96f0_0ff1_e2d4_b687_9a5c_3e1f_7042, 1'h0, -1, -1);
    dec_frame(137'h1_5ac3a5_96f0_0ff1_e2d4_b687_9a5c_3e1f_7042, 1'h0, 10, 91);
    dec_frame(137'h1_5ac3a5_96f0_0ff1_e2d4_b687_9a5c_3e1f_7042, 1'h1, -1, -1);
    dec_normal();
    results();
  end
endmodule // tb_top
